// file: rtl/bcus_core.sv
// flash array control, configuration load and security
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - new image is written to the flash array while user logic keeps running
// RQ2 - power-up load copies the stored flash image into configuration memory
// RQ3 - host reload command starts an immediate load without a power cycle
// RQ4 - user pins float with weak pull-up for the whole load
// RQ5 - security bit set refuses every readback of the flash array
// RQ6 - security bit clears only through a device erase
// RQ7 - configuration memory is never readable from outside
// RQ8 - user flash block stays accessible from port and logic regardless of security
// RQ9 - outputs stay disabled until power is good and load has completed
// RQ10 - load ends within its ceiling time before user mode
// RQ11 - user registers are cleared and released before pins are released; user_reg_clear drops in the same cycle the pins are driven
// RQ12 - reload requests during erase or program are ignored
module bcus_core #(
	parameter int LOAD_CYCLES = bcus_pkg::LOAD_CYCLES,
	parameter int AW = bcus_pkg::FLASH_AW,
	parameter int DW = bcus_pkg::DATA_W,
	parameter int OP_CYCLES = 4
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic power_good,
	input wire bcus_pkg::bcus_req_t host_req,
	output bcus_pkg::bcus_rsp_t host_rsp,
	output logic host_busy,
	input wire logic user_ufm_we,
	input wire logic [AW-1:0] user_ufm_addr,
	input wire logic [DW-1:0] user_ufm_wdata,
	output logic [DW-1:0] user_ufm_rdata,
	output logic [DW-1:0] config_word,
	output logic user_reg_clear,
	output logic pin_output_enable,
	output logic pin_pullup_enable,
	output logic secure,
	output logic user_mode
);
	localparam int DEPTH = 1 << AW;
	localparam int LCW = $clog2(LOAD_CYCLES + 1);
	localparam int OCW = $clog2(OP_CYCLES + 1);
	// load stops two short so the load plus its clear cycle fits the ceiling
	localparam logic [LCW-1:0] LOAD_LAST = LCW'(LOAD_CYCLES - 2);
	localparam logic [OCW-1:0] OP_LAST = OCW'(1);

	logic [DW-1:0] config_flash_array [DEPTH];
	logic [DW-1:0] user_flash_block [DEPTH];
	logic [DW-1:0] config_mem [DEPTH];
	bcus_pkg::bcus_state_t state;
	logic power_ok;
	logic [AW-1:0] load_addr;
	logic [LCW-1:0] load_count;
	logic [OCW-1:0] op_count;
	logic op_busy;
	logic erase_active;
	logic [AW-1:0] erase_addr;
	logic take;

	// supply monitor level arrives off this clock
	bcus_sync u_pwr_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.din(power_good),
		.dout(power_ok)
	);

	assign take = host_req.valid && !host_busy;
	// RQ12 loads hold the port off too, but an erase taken on the edge the load starts still writes the array mid-copy
	assign host_busy = op_busy || (state == bcus_pkg::BCUS_LOAD);

	// busy timer models the flash program and erase pulse
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			op_count <= '0;
			op_busy <= 1'b0;
			erase_active <= 1'b0;
			erase_addr <= '0;
		end else if (erase_active) begin
			erase_addr <= erase_addr + 1'b1;
			if (erase_addr == bcus_pkg::LAST_ADDR) begin
				erase_active <= 1'b0;
				op_busy <= 1'b0;
			end
		end else if (op_busy) begin
			op_count <= op_count - 1'b1;
			if (op_count == OP_LAST)
				op_busy <= 1'b0;
		end else if (take && host_req.cmd == bcus_pkg::BCUS_ERASE) begin
			erase_active <= 1'b1;
			erase_addr <= '0;
			op_busy <= 1'b1;
		end else if (take && (host_req.cmd == bcus_pkg::BCUS_PROG
				|| host_req.cmd == bcus_pkg::BCUS_UWRITE)) begin
			op_count <= OCW'(OP_CYCLES);
			op_busy <= 1'b1;
		end
	end

	// RQ1 background write
	always_ff @(posedge sys_clk) begin
		if (erase_active)
			config_flash_array[erase_addr] <= bcus_pkg::ERASED;
		else if (take && host_req.cmd == bcus_pkg::BCUS_PROG)
			config_flash_array[host_req.addr] <= host_req.data;
	end

	// port writes win over logic writes in one cycle; the logic write is lost
	// RQ8 user flash shared port and logic
	always_ff @(posedge sys_clk) begin
		if (erase_active)
			user_flash_block[erase_addr] <= bcus_pkg::ERASED;
		else if (take && host_req.cmd == bcus_pkg::BCUS_UWRITE)
			user_flash_block[host_req.addr] <= host_req.data;
		else if (user_mode && user_ufm_we)
			user_flash_block[user_ufm_addr] <= user_ufm_wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			user_ufm_rdata <= bcus_pkg::BLANK;
		else
			user_ufm_rdata <= user_flash_block[user_ufm_addr];
	end

	// security bit lives in flash, survives reset
	always_ff @(posedge sys_clk) begin
		// RQ6 cleared only by erase
		if (take && host_req.cmd == bcus_pkg::BCUS_ERASE)
			secure <= 1'b0;
		else if (take && host_req.cmd == bcus_pkg::BCUS_SECURE)
			secure <= 1'b1;
	end

	// host answers one cycle after the request is taken
	// refused reads answer blank data, so nothing of the image leaks
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			host_rsp <= '0;
		end else begin
			host_rsp.valid <= take;
			host_rsp.refused <= 1'b0;
			host_rsp.data <= bcus_pkg::BLANK;
			if (take) begin
				unique case (host_req.cmd)
					bcus_pkg::BCUS_READ: begin
						// RQ5 secure refuses readback
						if (secure)
							host_rsp.refused <= 1'b1;
						else
							host_rsp.data <= config_flash_array[host_req.addr];
					end
					// RQ8 no security gate
					bcus_pkg::BCUS_UREAD:
						host_rsp.data <= user_flash_block[host_req.addr];
					default:
						host_rsp.refused <= 1'b0;
				endcase
			end
		end
	end

	// load sequencer; reset stands in for the power cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= bcus_pkg::BCUS_OFF;
			load_addr <= '0;
			load_count <= '0;
		end else begin
			unique case (state)
				bcus_pkg::BCUS_OFF: begin
					// a pending flash operation holds the load off
					// RQ2 power-up load
					if (power_ok && !op_busy) begin
						state <= bcus_pkg::BCUS_LOAD;
						load_addr <= '0;
						load_count <= '0;
					end
				end
				bcus_pkg::BCUS_LOAD: begin
					load_addr <= load_addr + 1'b1;
					load_count <= load_count + 1'b1;
					// RQ10 bounded load time
					if (load_addr == bcus_pkg::LAST_ADDR
							|| load_count == LOAD_LAST)
						state <= bcus_pkg::BCUS_CLEAR;
				end
				// RQ11 clear before pin release
				bcus_pkg::BCUS_CLEAR:
					state <= bcus_pkg::BCUS_USER;
				bcus_pkg::BCUS_USER: begin
					// brown-out reruns the load
					if (!power_ok)
						state <= bcus_pkg::BCUS_OFF;
					// RQ3 immediate reload; RQ12 not while flash busy
					else if (take && host_req.cmd == bcus_pkg::BCUS_RELOAD)
						state <= bcus_pkg::BCUS_OFF;
				end
			endcase
		end
	end

	// config word feeds only the logic array, never the host
	// RQ7 config memory has no read path out
	always_ff @(posedge sys_clk) begin
		if (state == bcus_pkg::BCUS_LOAD)
			config_mem[load_addr] <= config_flash_array[load_addr];
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			config_word <= bcus_pkg::BLANK;
		else
			config_word <= config_mem[user_ufm_addr];
	end

	// RQ4 pins float with pull-up; RQ9 outputs held off
	assign user_mode = (state == bcus_pkg::BCUS_USER);
	assign pin_output_enable = user_mode;
	assign pin_pullup_enable = !user_mode;
	assign user_reg_clear = (state != bcus_pkg::BCUS_USER);
endmodule // bcus_core

// file: rtl/bcus_pkg.sv
// package for the background configuration update and security block
package bcus_pkg;
	// configuration load ceiling in microseconds
	localparam int LOAD_MAX_US = 450;
	localparam int CLK_MHZ = 40;
	// longest time rounds down to whole cycles
	localparam int LOAD_CYCLES = LOAD_MAX_US * CLK_MHZ;
	localparam int FLASH_AW = 8;
	localparam int DATA_W = 8;
	localparam logic [FLASH_AW-1:0] LAST_ADDR = 8'hFF;
	localparam logic [DATA_W-1:0] ERASED = 8'hFF;
	localparam logic [DATA_W-1:0] BLANK = 8'h00;

	// host commands over the programming port
	typedef enum logic [2:0] {
		BCUS_NOP = 3'h0,
		BCUS_ERASE = 3'h1,
		BCUS_PROG = 3'h2,
		BCUS_READ = 3'h3,
		BCUS_SECURE = 3'h4,
		BCUS_RELOAD = 3'h5,
		BCUS_UREAD = 3'h6,
		BCUS_UWRITE = 3'h7
	} bcus_cmd_t;

	typedef struct packed {
		logic valid;
		bcus_cmd_t cmd;
		logic [FLASH_AW-1:0] addr;
		logic [DATA_W-1:0] data;
	} bcus_req_t;

	typedef struct packed {
		logic valid;
		logic refused;
		logic [DATA_W-1:0] data;
	} bcus_rsp_t;

	// load sequence, gray along the path
	typedef enum logic [1:0] {
		BCUS_OFF = 2'b00,
		BCUS_LOAD = 2'b01,
		BCUS_CLEAR = 2'b11,
		BCUS_USER = 2'b10
	} bcus_state_t;
endpackage

// file: rtl/bcus_sync.sv
// two flop synchroniser for pin levels
`timescale 1ns/1ps
module bcus_sync (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	logic stage1;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stage1 <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule // bcus_sync

// file: test/bcus_core_props.sv
// assertions on the configuration core ports
`timescale 1ns/1ps
module bcus_props #(parameter int LOAD_CYCLES = 300) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic power_good,
	input wire bcus_pkg::bcus_req_t host_req,
	input wire bcus_pkg::bcus_rsp_t host_rsp,
	input wire logic host_busy,
	input wire logic user_reg_clear,
	input wire logic pin_output_enable,
	input wire logic pin_pullup_enable,
	input wire logic secure,
	input wire logic user_mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic tk, rd, rl, wr, er;
	logic [15:0] cnt;
	assign tk = host_req.valid && !host_busy;
	assign rd = tk && host_req.cmd == bcus_pkg::BCUS_READ;
	assign rl = tk && host_req.cmd == bcus_pkg::BCUS_RELOAD;
	assign er = tk && host_req.cmd == bcus_pkg::BCUS_ERASE;
	assign wr = tk && (host_req.cmd == bcus_pkg::BCUS_PROG || er);
	// load time since supplies came good
	always_ff @(posedge sys_clk) begin
		if (reset || user_mode || !power_good) cnt <= '0;
		else cnt <= cnt + 16'h0001;
	end
	a_pins_float: assert property (!user_mode |-> !pin_output_enable && pin_pullup_enable)
		else $error("pins driven outside user mode");
	a_pull_pair: assert property (pin_pullup_enable != pin_output_enable)
		else $error("pull-up and drive disagree");
	a_clear_first: assert property ($rose(pin_output_enable) |-> $past(user_reg_clear)
		&& !user_reg_clear) else $error("pins released before clear");
	a_read_refuse: assert property (rd && secure |=> host_rsp.valid && host_rsp.refused
		&& host_rsp.data == 8'h00) else $error("secured read not refused");
	a_reload_go: assert property (rl && user_mode |=> !user_mode)
		else $error("reload not started");
	a_busy_ignore: assert property (host_req.valid && host_busy && user_mode |=> user_mode)
		else $error("request taken while busy");
	a_keep_run: assert property (wr && user_mode |=> user_mode [*4])
		else $error("user mode halted by flash write");
	a_secure_keep: assert property ($fell(secure) |-> $past(er))
		else $error("security cleared without erase");
	a_load_bound: assert property (cnt <= LOAD_CYCLES + 8)
		else $error("load took too long");
	c_reload: cover property (rl && user_mode);
	c_refused: cover property (host_rsp.valid && host_rsp.refused);
	c_unlock: cover property ($fell(secure));
endmodule // bcus_props
bind bcus_core bcus_props #(.LOAD_CYCLES(LOAD_CYCLES)) u_props (.sys_clk, .reset,
	.power_good, .host_req, .host_rsp, .host_busy, .user_reg_clear, .pin_output_enable,
	.pin_pullup_enable, .secure, .user_mode);

// file: test/bcus_host.sv
// programming host model on the request port
`timescale 1ns/1ps
module bcus_host (
	input wire logic sys_clk,
	input wire logic host_busy,
	input wire bcus_pkg::bcus_rsp_t host_rsp,
	output bcus_pkg::bcus_req_t host_req
);
	initial host_req = '0;
	task automatic op(input bcus_pkg::bcus_cmd_t c, input logic [7:0] a, d,
		input logic pushy, output bcus_pkg::bcus_rsp_t r);
		@(negedge sys_clk);
		while (!pushy && host_busy) @(negedge sys_clk);
		host_req = {1'b1, c, a, d};
		@(negedge sys_clk);
		// answer stands in the cycle after the taking edge
		r = host_rsp;
		// released fields go stale on purpose
		host_req = {1'b0, bcus_pkg::BCUS_NOP, ~a, ~d};
	endtask
endmodule // bcus_host

// file: test/bcus_tb.sv
// self-checking bench for the configuration core
`timescale 1ns/1ps
module bcus_core_tb;
	logic sys_clk = 0, reset = 1, power_good = 0, we = 0;
	logic [7:0] ua = 0, ud = 0, ur, cw, a, d;
	bcus_pkg::bcus_req_t req;
	bcus_pkg::bcus_rsp_t r, rsp;
	logic busy, clr, oe, pu, sec, um;
	int error_cnt = 0, comparisons = 0;
	initial forever #12.5 sys_clk = ~sys_clk;
	bcus_core #(.LOAD_CYCLES(300)) dut (.sys_clk, .reset, .power_good, .host_req(req),
		.host_rsp(rsp), .host_busy(busy), .user_ufm_we(we), .user_ufm_addr(ua),
		.user_ufm_wdata(ud), .user_ufm_rdata(ur), .config_word(cw),
		.user_reg_clear(clr), .pin_output_enable(oe), .pin_pullup_enable(pu),
		.secure(sec), .user_mode(um));
	bcus_host u_host (.sys_clk, .host_busy(busy), .host_rsp(rsp), .host_req(req));
	function logic [7:0] exp_rd(input logic s, input logic [7:0] v);
		return s ? 8'h00 : v;
	endfunction
	task chk(input logic [7:0] g, e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wrap_up;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_user;
		for (int n = 0; n < 310 && um !== 1'b1; n++) @(negedge sys_clk);
		chk(um, 1);
		chk(pu, 0);
		chk(clr, 0);
	endtask
	task boot;
		reset = 1;
		power_good = 0;
		repeat (12) @(negedge sys_clk);
		reset = 0;
		repeat (20) @(negedge sys_clk);
		chk(oe, 0);
		power_good = 1;
		wait_user;
	endtask
	initial begin
		#150000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		void'($urandom(32'h655A));
		boot;
		u_host.op(bcus_pkg::BCUS_ERASE, 8'h00, 8'h00, 0, r);
		u_host.op(bcus_pkg::BCUS_NOP, 8'h00, 8'h00, 0, r);
		chk(r.valid, 1);
		chk(sec, 0);
		for (int i = 0; i < 4; i++) begin
			a = {1'b0, i[1:0], 5'($urandom)};
			d = 8'($urandom);
			u_host.op(bcus_pkg::BCUS_PROG, a, d, 0, r);
			chk(um, 1);
			u_host.op(bcus_pkg::BCUS_READ, a, 8'h00, 0, r);
			chk(r.data, exp_rd(0, d));
			u_host.op(bcus_pkg::BCUS_UWRITE, a, ~d, 0, r);
			u_host.op(bcus_pkg::BCUS_UREAD, a, 8'h00, 0, r);
			chk(r.data, ~d);
		end
		@(negedge sys_clk) we = 1;
		ua = 8'hFF;
		ud = 8'h5A;
		@(negedge sys_clk) we = 0;
		@(negedge sys_clk);
		chk(ur, 8'h5A);
		u_host.op(bcus_pkg::BCUS_SECURE, 8'h00, 8'h00, 0, r);
		u_host.op(bcus_pkg::BCUS_NOP, 8'h00, 8'h00, 0, r);
		chk(sec, 1);
		u_host.op(bcus_pkg::BCUS_READ, a, 8'h00, 0, r);
		chk(r.refused, 1);
		chk(r.data, exp_rd(1, d));
		u_host.op(bcus_pkg::BCUS_UREAD, 8'hFF, 8'h00, 0, r);
		chk(r.data, 8'h5A);
		a = {1'b1, 7'($urandom)};
		d = 8'($urandom);
		u_host.op(bcus_pkg::BCUS_PROG, a, d, 0, r);
		chk(busy, 1);
		u_host.op(bcus_pkg::BCUS_RELOAD, 8'h00, 8'h00, 1, r);
		chk(r.valid, 0);
		chk(um, 1);
		u_host.op(bcus_pkg::BCUS_RELOAD, 8'h00, 8'h00, 0, r);
		chk(um, 0);
		chk(oe, 0);
		chk(clr, 1);
		repeat (100) @(negedge sys_clk);
		chk(pu, 1);
		wait_user;
		ua = a;
		repeat (2) @(negedge sys_clk);
		chk(cw, d);
		// brown-out reruns the load from the stored image
		power_good = 0;
		repeat (4) @(negedge sys_clk);
		chk(oe, 0);
		chk(clr, 1);
		power_good = 1;
		wait_user;
		chk(cw, d);
		d = ~d;
		u_host.op(bcus_pkg::BCUS_PROG, a, d, 0, r);
		repeat (8) @(negedge sys_clk);
		chk(cw, ~d);
		boot;
		chk(sec, 1);
		chk(cw, d);
		u_host.op(bcus_pkg::BCUS_ERASE, 8'h00, 8'h00, 0, r);
		u_host.op(bcus_pkg::BCUS_READ, a, 8'h00, 0, r);
		chk(sec, 0);
		chk(r.data, 8'hFF);
		wrap_up;
	end
endmodule // bcus_core_tb
